// ==== tbsd_pkg.sv ====
// Purpose: Constants for the touch button state detector
// Assumes: 50 MHz pclk, APB register access
// Notes:
package tbsd_pkg;
  localparam int          RAW_W      = 16;      // Raw count width
  localparam int          NBTN       = 10;      // Button inputs
  localparam int          NCH        = 12;      // Buttons, guard, gang
  localparam logic [3:0]  IDX_GUARD  = 4'ha;    // Guard sensor index
  localparam logic [3:0]  IDX_GANG   = 4'hb;    // Ganged scan index
  localparam int          CLK_HZ     = 50000000;
  localparam int          MS_CYC     = CLK_HZ / 1000;  // Cycles per ms
  localparam logic [9:0]  SCAN_SLOW_MS = 10'h12a;  // 298 ms
  localparam logic [9:0]  SCAN_FAST_MS = 10'h0d2;  // 210 ms
  localparam logic [9:0]  ON_TIME_MS   = 10'h3e8;  // 1000 ms
  localparam logic [6:0]  DEB_FIXED  = 7'h03;   // Inputs one to nine
  localparam logic [6:0]  DEB_24     = 7'h18;
  localparam logic [6:0]  DEB_48     = 7'h30;
  localparam logic [6:0]  DEB_99     = 7'h63;
  localparam logic [6:0]  DEB_MAX    = 7'h7f;   // Counter saturation
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_NOISE  = 8'h04;
  localparam logic [7:0]  OFS_NEG    = 8'h08;
  localparam logic [7:0]  OFS_FINGER = 8'h0c;
  localparam logic [7:0]  OFS_HYST   = 8'h10;
  localparam logic [7:0]  OFS_LOWBL  = 8'h14;
  localparam logic [7:0]  OFS_STATE  = 8'h18;
  localparam logic [7:0]  OFS_INTST  = 8'h1c;
  localparam logic [7:0]  OFS_INTMSK = 8'h20;
  localparam logic [7:0]  OFS_STRAP  = 8'h24;
  // Control fields and reset values
  localparam int          CTRL_GANG  = 0;
  localparam int          CTRL_GUARD = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [15:0] NOISE_RST  = 16'h0020;
  localparam logic [15:0] NEG_RST    = 16'h0020;
  localparam logic [15:0] FINGER_RST = 16'h0080;
  localparam logic [15:0] HYST_RST   = 16'h0010;
  localparam logic [7:0]  LOWBL_RST  = 8'h1e;
  localparam int          INT_W      = 11;      // Ten touches plus guard
endpackage : tbsd_pkg

// ==== tbsd_chan.sv ====
// Purpose: One sensor channel: difference, baseline, debounced state
// Assumes: sample_valid pulses once per scan of this sensor
// Notes: First sample after reset seeds the baseline
`timescale 1ns/100ps
`default_nettype none
module tbsd_chan (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        sample_valid,
  input  wire logic [15:0] raw_count,
  input  wire logic [15:0] noise_th,
  input  wire logic [15:0] neg_noise_th,
  input  wire logic [15:0] finger_th,
  input  wire logic [15:0] hyst,
  input  wire logic [6:0]  debounce,
  input  wire logic [7:0]  low_limit,
  input  wire logic        auto_clear,
  output logic             touch,
  output logic [15:0]      diff_count
);
  logic [15:0] bl_ff, nxt_bl;         // Baseline
  logic        init_ff, nxt_init;     // Baseline seeded
  logic [7:0]  low_ff, nxt_low;       // Samples spent far below
  logic [6:0]  deb_ff, nxt_deb;       // Samples above on level
  logic        touch_ff, nxt_touch;   // Debounced state
  logic [15:0] diff_ff, nxt_diff;     // Reported difference
  logic        raw_gt;
  logic [15:0] rdiff, ndiff, diff;
  logic        on_lvl, off_lvl;
  localparam logic [6:0] DEB_MAX_L = tbsd_pkg::DEB_MAX;  // Counter ceiling

  //////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    raw_gt  = raw_count > bl_ff;
    rdiff   = raw_count - bl_ff;
    ndiff   = bl_ff - raw_count;
    diff    = (raw_gt && rdiff >= noise_th) ? rdiff : 16'h0000;
    // Compare in 17 bits so threshold sums cannot wrap
    on_lvl  = {1'b0, diff} > ({1'b0, finger_th} + {1'b0, hyst});
    off_lvl = ({1'b0, diff} + {1'b0, hyst}) < {1'b0, finger_th};
    nxt_bl    = bl_ff;
    nxt_init  = init_ff;
    nxt_low   = low_ff;
    nxt_deb   = deb_ff;
    nxt_touch = touch_ff;
    nxt_diff  = diff_ff;
    if (sample_valid && !init_ff) begin
      // Seed the baseline
      nxt_bl   = raw_count;
      nxt_init = 1'b1;
    end else if (sample_valid) begin
      nxt_diff = diff;
      if (on_lvl) begin
        // Count consecutive samples, saturating
        if (deb_ff != DEB_MAX_L) nxt_deb = deb_ff + 7'h01;
        if (deb_ff + 7'h01 >= debounce) nxt_touch = 1'b1;
      end else begin
        nxt_deb = 7'h00;
        if (off_lvl) nxt_touch = 1'b0;
      end
      if (!raw_gt && ndiff >= neg_noise_th) begin
        // Far below: no tracking, count toward reload
        if (low_ff >= low_limit) begin
          nxt_bl  = raw_count;
          nxt_low = 8'h00;
        end else begin
          nxt_low = low_ff + 8'h01;
        end
      end else begin
        nxt_low = 8'h00;
        // Slow one-count step; baseline steps during touches only when auto_clear is set
        if (auto_clear || diff == 16'h0000) begin
          if (raw_gt) nxt_bl = bl_ff + 16'h0001;
          else if (raw_count < bl_ff) nxt_bl = bl_ff - 16'h0001;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_ff    <= 16'h0000;
      init_ff  <= 1'b0;
      low_ff   <= 8'h00;
      deb_ff   <= 7'h00;
      touch_ff <= 1'b0;
      diff_ff  <= 16'h0000;
    end else begin
      bl_ff    <= nxt_bl;
      init_ff  <= nxt_init;
      low_ff   <= nxt_low;
      deb_ff   <= nxt_deb;
      touch_ff <= nxt_touch;
      diff_ff  <= nxt_diff;
    end
  end
  assign touch      = touch_ff;
  assign diff_count = diff_ff;

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_diff_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && init_ff |=> diff_count == 16'h0000 || diff_count >= $past(noise_th))
    else $error("difference below noise not clamped");
  a_touch_level: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(touch_ff) |-> {1'b0, diff_ff} > ({1'b0, $past(finger_th)} + {1'b0, $past(hyst)}))
    else $error("touch set below on level");
  a_debounce_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(touch_ff) |-> $past(deb_ff) + 7'h01 >= $past(debounce))
    else $error("touch set before debounce count");
  a_release_level: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(touch_ff) |-> ({1'b0, diff_ff} + {1'b0, $past(hyst)}) < {1'b0, $past(finger_th)})
    else $error("touch cleared above off level");
  a_low_reload: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && init_ff && !raw_gt && ndiff >= neg_noise_th && low_ff >= low_limit
    |=> bl_ff == $past(raw_count))
    else $error("baseline not reloaded");
  c_touch_seen: cover property (@(posedge pclk) disable iff (!presetn) $rose(touch_ff));
endmodule : tbsd_chan
`default_nettype wire

// ==== tbsd_top.sv ====
// Purpose: Ten-button touch state detector with APB registers
// Assumes: Front end delivers raw counts tagged by sensor index
// Notes: Index 10 is the guard sensor, index 11 the ganged scan
`timescale 1ns/100ps
`default_nettype none
module tbsd_top #(
  parameter int MS_CYC = tbsd_pkg::MS_CYC  // Cycles per millisecond
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scan_period_strap,
  input  wire logic [1:0]  auto_clear_immunity_strap,
  input  wire logic        lamp_effect_strap,
  input  wire logic        on_time_strap,
  input  wire logic [1:0]  input_zero_gain_strap,
  input  wire logic        raw_valid,
  input  wire logic [3:0]  raw_index,
  input  wire logic [15:0] raw_count,
  output logic             scan_req,
  output logic             scan_gang,
  output logic             noise_high,
  output logic [9:0]       button_output,
  output logic             backlight_out,
  output logic             analog_mode,
  output logic             irq
);
  localparam int NB = tbsd_pkg::NBTN;
  localparam int NC = tbsd_pkg::NCH;
  localparam int IW = tbsd_pkg::INT_W;

  //////////////////////////////////////////////////////////////////////
  // Strap capture, once per reset
  logic       strap_done_ff;
  logic       fast_ff, auto_ff, high_ff, analog_en_ff, ontime_en_ff;
  logic [1:0] gain_ff;
  logic [6:0] deb0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_ff <= 1'b0;
      fast_ff       <= 1'b0;
      auto_ff       <= 1'b0;
      high_ff       <= 1'b0;
      analog_en_ff  <= 1'b0;
      ontime_en_ff  <= 1'b0;
      gain_ff       <= 2'h0;
    end else if (!strap_done_ff) begin
      // Pins sampled at the first edge after release, then frozen
      strap_done_ff <= 1'b1;
      fast_ff       <= scan_period_strap;
      auto_ff       <= auto_clear_immunity_strap != 2'h0;
      high_ff       <= auto_clear_immunity_strap[1];
      analog_en_ff  <= lamp_effect_strap;
      ontime_en_ff  <= on_time_strap;
      gain_ff       <= input_zero_gain_strap;
    end
  end
  // Input zero debounce choice
  always_comb begin
    unique case (gain_ff)
      2'h0: deb0 = tbsd_pkg::DEB_FIXED;
      2'h1: deb0 = tbsd_pkg::DEB_24;
      2'h2: deb0 = tbsd_pkg::DEB_48;
      2'h3: deb0 = tbsd_pkg::DEB_99;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Millisecond enable and scan period timer
  logic [15:0] ms_ff, nxt_ms;
  logic [9:0]  scan_ff, nxt_scan;
  logic        ms_tick, req_ff, nxt_req;
  logic [9:0]  period;
  always_comb begin
    ms_tick  = ms_ff == 16'(MS_CYC - 1);
    nxt_ms   = ms_tick ? 16'h0000 : ms_ff + 16'h0001;
    period   = fast_ff ? tbsd_pkg::SCAN_FAST_MS : tbsd_pkg::SCAN_SLOW_MS;
    nxt_scan = scan_ff;
    nxt_req  = 1'b0;
    if (strap_done_ff && ms_tick) begin
      if (scan_ff >= period - 10'h001) begin
        nxt_scan = 10'h000;
        nxt_req  = 1'b1;
      end else begin
        nxt_scan = scan_ff + 10'h001;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_ff   <= 16'h0000;
      scan_ff <= 10'h000;
      req_ff  <= 1'b0;
    end else begin
      ms_ff   <= nxt_ms;
      scan_ff <= nxt_scan;
      req_ff  <= nxt_req;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers held by software
  logic [1:0]    ctrl_ff;
  logic [15:0]   noise_ff, neg_ff, finger_ff, hyst_ff;
  logic [7:0]    lowbl_ff;
  logic [IW-1:0] int_ff, nxt_int, mask_ff, events;
  logic [NC-1:0] touch, ch_valid;
  logic [NB-1:0] prev_ff;
  logic          guard_on, guard_q_ff;

  //////////////////////////////////////////////////////////////////////
  // Sample routing and channels
  // Guard hit blocks button samples; guard itself keeps scanning
  assign guard_on = ctrl_ff[tbsd_pkg::CTRL_GUARD] && touch[tbsd_pkg::IDX_GUARD];
  // Ganged scan only while idle; a gang hit forces per-button scans
  assign scan_gang = ctrl_ff[tbsd_pkg::CTRL_GANG] && !(|touch[NB-1:0])
                     && !touch[tbsd_pkg::IDX_GANG];
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_ch
      if (gi < NB) begin : g_btn
        assign ch_valid[gi] = raw_valid && raw_index == 4'(gi) && !guard_on;
      end else begin : g_aux
        assign ch_valid[gi] = raw_valid && raw_index == 4'(gi);
      end
      tbsd_chan u_chan (
        .pclk         (pclk),
        .presetn      (presetn),
        .sample_valid (ch_valid[gi]),
        .raw_count    (raw_count),
        .noise_th     (noise_ff),
        .neg_noise_th (neg_ff),
        .finger_th    (finger_ff),
        .hyst         (hyst_ff),
        .debounce     ((gi == 0) ? deb0 : tbsd_pkg::DEB_FIXED),
        .low_limit    (lowbl_ff),
        .auto_clear   (auto_ff),
        .touch        (touch[gi]),
        .diff_count   ()
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Output hold timers, one per button
  logic [NB-1:0] out_ff;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_out
      logic [9:0] hold_ff, nxt_hold;
      logic       nxt_out, bit_ff;  // One driver per output bit
      assign out_ff[gi] = bit_ff;
      always_comb begin
        nxt_hold = hold_ff;
        if (touch[gi]) nxt_hold = tbsd_pkg::ON_TIME_MS;
        else if (ms_tick && hold_ff != 10'h000) nxt_hold = hold_ff - 10'h001;
        // Analog network needs live states, so no extension there
        if (analog_en_ff || !ontime_en_ff) nxt_out = touch[gi];
        else nxt_out = touch[gi] || hold_ff != 10'h000;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold_ff    <= 10'h000;
          bit_ff     <= 1'b0;
        end else begin
          hold_ff    <= nxt_hold;
          bit_ff     <= nxt_out;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  logic        setup, wr, rd_int;
  logic [31:0] rd_data, prdata_ff;
  logic        hit, err_ff;
  always_comb begin
    setup   = psel && !penable;
    wr      = psel && penable && pwrite;
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr)
      tbsd_pkg::OFS_CTRL:   rd_data = {30'h0, ctrl_ff};
      tbsd_pkg::OFS_NOISE:  rd_data = {16'h0, noise_ff};
      tbsd_pkg::OFS_NEG:    rd_data = {16'h0, neg_ff};
      tbsd_pkg::OFS_FINGER: rd_data = {16'h0, finger_ff};
      tbsd_pkg::OFS_HYST:   rd_data = {16'h0, hyst_ff};
      tbsd_pkg::OFS_LOWBL:  rd_data = {24'h0, lowbl_ff};
      tbsd_pkg::OFS_STATE:  rd_data = {20'h0, touch};
      tbsd_pkg::OFS_INTST:  rd_data = {21'h0, int_ff};
      tbsd_pkg::OFS_INTMSK: rd_data = {21'h0, mask_ff};
      tbsd_pkg::OFS_STRAP:  rd_data = {26'h0, gain_ff, ontime_en_ff, analog_en_ff, high_ff, fast_ff};
      default:              hit = 1'b0;
    endcase
    // Cleared as it is captured, so no event slips between
    rd_int  = setup && !pwrite && paddr == tbsd_pkg::OFS_INTST;
    events  = {touch[tbsd_pkg::IDX_GUARD] && !guard_q_ff, touch[NB-1:0] & ~prev_ff};
    nxt_int = (rd_int ? {IW{1'b0}} : int_ff) | events; // Set wins
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= tbsd_pkg::CTRL_RST;
      noise_ff   <= tbsd_pkg::NOISE_RST;
      neg_ff     <= tbsd_pkg::NEG_RST;
      finger_ff  <= tbsd_pkg::FINGER_RST;
      hyst_ff    <= tbsd_pkg::HYST_RST;
      lowbl_ff   <= tbsd_pkg::LOWBL_RST;
      mask_ff    <= {IW{1'b0}};
      int_ff     <= {IW{1'b0}};
      prev_ff    <= {NB{1'b0}};
      guard_q_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      err_ff     <= 1'b0;
    end else begin
      int_ff     <= nxt_int;
      prev_ff    <= touch[NB-1:0];
      guard_q_ff <= touch[tbsd_pkg::IDX_GUARD];
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
        err_ff    <= !hit;
      end
      if (wr) begin
        unique case (paddr)
          tbsd_pkg::OFS_CTRL:   ctrl_ff   <= pwdata[1:0];
          tbsd_pkg::OFS_NOISE:  noise_ff  <= pwdata[15:0];
          tbsd_pkg::OFS_NEG:    neg_ff    <= pwdata[15:0];
          tbsd_pkg::OFS_FINGER: finger_ff <= pwdata[15:0];
          tbsd_pkg::OFS_HYST:   hyst_ff   <= pwdata[15:0];
          tbsd_pkg::OFS_LOWBL:  lowbl_ff  <= pwdata[7:0];
          tbsd_pkg::OFS_INTMSK: mask_ff   <= pwdata[IW-1:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata        = prdata_ff;
  assign pready        = 1'b1;
  assign pslverr       = err_ff && psel && penable;
  assign scan_req      = req_ff;
  assign noise_high    = high_ff;
  assign button_output = out_ff;
  assign backlight_out = analog_en_ff;
  assign analog_mode   = analog_en_ff;
  assign irq           = |(int_ff & mask_ff);

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_guard_block: assert property (@(posedge pclk) disable iff (!presetn)
    guard_on |-> ch_valid[NB-1:0] == {NB{1'b0}})
    else $error("button sample passed during guard hit");
  a_direct_follow: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done_ff && !ontime_en_ff |=> button_output == $past(touch[NB-1:0]))
    else $error("outputs not following state");
  a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
    ontime_en_ff && !analog_en_ff && $fell(touch[0]) |-> ##1 button_output[0])
    else $error("on-time not extended");
  a_strap_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done_ff |=> $stable(fast_ff) && $stable(auto_ff) && $stable(ontime_en_ff))
    else $error("strap changed after latch");
  a_scan_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    scan_req |=> !scan_req [*8])
    else $error("scan requests too close");
  a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_int && events == {IW{1'b0}} |=> int_ff == {IW{1'b0}})
    else $error("status not cleared by read");
  c_gang_wake: cover property (@(posedge pclk) disable iff (!presetn) $fell(scan_gang));
  c_guard_hit: cover property (@(posedge pclk) disable iff (!presetn) $rose(guard_on));
  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : tbsd_top
`default_nettype wire

// ==== tbsd_front.sv ====
// Purpose: Front-end model that delivers raw counts for each scan round
// Assumes: One round per scan_req; a ganged round sends index 11 only
// Notes: The count line toggles when idle, so a stale value never looks valid
`timescale 1ns/100ps
`default_nettype none
module tbsd_front #(
  parameter int GAP = 2  // Idle cycles before each sample
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        scan_req,
  input  wire logic        scan_gang,
  input  wire logic [11:0] touch_mask,  // Sensors with a finger on them
  input  wire logic [15:0] delta,       // Count shift of a finger, wraps
  output logic             raw_valid,
  output logic [3:0]       raw_index,
  output logic [15:0]      raw_count
);
  logic       busy_ff;  // Round in progress
  logic       gang_ff;  // Round is ganged
  logic [3:0] seq_ff;   // Samples sent so far
  logic [3:0] gap_ff;   // Spacing countdown
  logic [3:0] idx;      // Sensor of the next sample
  // Guard first, so its state is known before the buttons
  assign idx = gang_ff ? 4'hb : ((seq_ff == 4'h0) ? 4'ha : seq_ff - 4'h1);
  ////////////////////////////////////////////////////////////////////////
  // Round sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff   <= 1'b0;
      gang_ff   <= 1'b0;
      seq_ff    <= 4'h0;
      gap_ff    <= 4'h0;
      raw_valid <= 1'b0;
      raw_index <= 4'h0;
      raw_count <= 16'h0;
    end else begin
      raw_valid <= 1'b0;
      raw_count <= ~raw_count;  // Released line: changes every cycle
      if (!busy_ff && scan_req) begin
        busy_ff <= 1'b1;
        gang_ff <= scan_gang;
        seq_ff  <= 4'h0;
        gap_ff  <= 4'(GAP);
      end else if (busy_ff && gap_ff != 4'h0) begin
        gap_ff <= gap_ff - 4'h1;
      end else if (busy_ff) begin
        raw_valid <= 1'b1;
        raw_index <= idx;
        raw_count <= 16'h03e8 + (touch_mask[idx] ? delta : 16'h0);
        seq_ff    <= seq_ff + 4'h1;
        gap_ff    <= 4'(GAP);
        busy_ff   <= !(gang_ff || seq_ff == 4'ha);  // Last sample ends round
      end
    end
  end
endmodule : tbsd_front
`default_nettype wire

// ==== tbsd_top_tb.sv ====
// Purpose: Self-checking bench for the touch button state detector
// Assumes: MS_CYC of 1, so one millisecond tick is one pclk
// Notes: Front-end model answers every scan request with a full round, or with index 11 alone when ganged
`timescale 1ns/100ps
`default_nettype none
module tbsd_top_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, scan_req, scan_gang, noise_high, err;
  logic        backlight_out, analog_mode, irq, raw_valid;
  logic [9:0]  button_output;
  logic [3:0]  raw_index;
  logic [15:0] raw_count;
  logic        s_fast = 1'b1, s_lamp = 1'b0, s_on = 1'b0;  // Straps
  logic [1:0]  s_auto = 2'h0, s_gain = 2'h0;
  logic [11:0] mask = 12'h0;      // Fingers seen by the front end
  logic [15:0] delta = 16'h0200;  // Finger signal, well above threshold
  int          fail_count = 0;
  int          num_checks = 0;
  always #10 pclk = ~pclk;
  tbsd_top #(.MS_CYC(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_period_strap(s_fast), .auto_clear_immunity_strap(s_auto),
    .lamp_effect_strap(s_lamp), .on_time_strap(s_on), .input_zero_gain_strap(s_gain),
    .raw_valid(raw_valid), .raw_index(raw_index), .raw_count(raw_count),
    .scan_req(scan_req), .scan_gang(scan_gang), .noise_high(noise_high),
    .button_output(button_output), .backlight_out(backlight_out),
    .analog_mode(analog_mode), .irq(irq));
  tbsd_front #(.GAP(2)) front (.pclk(pclk), .presetn(presetn), .scan_req(scan_req),
    .scan_gang(scan_gang), .touch_mask(mask), .delta(delta), .raw_valid(raw_valid),
    .raw_index(raw_index), .raw_count(raw_count));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic give_up(input string what);
    fail_count++;
    $display("ERROR %0t timeout: %s", $time, what);
    end_of_test();
  endtask : give_up
  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask : chk1
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk32
  ////////////////////////////////////////////////////////////////////////
  // Bus, reset and scan helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;  // Setup cycle
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;  // Access until ready
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up("no pready");
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic reset_dut(input logic f, input logic [1:0] a, input logic l,
                           input logic o, input logic [1:0] g);
    @(posedge pclk);
    presetn <= 1'b0;
    {s_fast, s_auto, s_lamp, s_on, s_gain} <= {f, a, l, o, g};
    mask    <= 12'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);  // Straps latched and settled
  endtask : reset_dut
  // Bounded wait for a scan request, then for its round to land
  task automatic wait_scans(input int n);
    int t;
    repeat (n) begin
      t = 0;
      while (scan_req !== 1'b1) begin
        @(posedge pclk);
        t++;
        if (t > 400) give_up("no scan request");
      end
      repeat (40) @(posedge pclk);
    end
  endtask : wait_scans
  task automatic t_period(input int ms);
    int t;
    for (int k = 0; k < 2; k++) begin
      t = 0;
      do begin
        @(posedge pclk);
        t++;
      end while (scan_req !== 1'b1 && t < 400);
    end
    chk32(t, ms, "scan period");
    repeat (40) @(posedge pclk);  // Round in flight lands first
  endtask : t_period
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [7:0]  a[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24};
    logic [31:0] e[7] = '{32'h0, 32'h20, 32'h20, 32'h80, 32'h10, 32'h1e, 32'h1};
    chk32({22'h0, button_output}, 32'h0, "outputs after reset");
    chk1(backlight_out, 1'b0, "backlight without analog");
    chk1(noise_high, 1'b0, "normal immunity");
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk32(rd, e[i], "reset value");
    end
    apb(1'b1, tbsd_pkg::OFS_STRAP, 32'hff);
    s_fast <= 1'b0;  // Strap moves after the latch
    apb(1'b0, tbsd_pkg::OFS_STRAP, 32'h0);
    chk32(rd, 32'h1, "strap latch held");
    apb(1'b0, 8'h30, 32'h0);
    chk1(err, 1'b1, "unmapped error");
    t_period(210);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_touch;
    apb(1'b1, tbsd_pkg::OFS_INTMSK, 32'h3ff);
    mask <= 12'h008;
    wait_scans(2);
    chk1(button_output[3], 1'b0, "two samples only");
    wait_scans(1);
    chk1(button_output[3], 1'b1, "touch after debounce");
    chk1(irq, 1'b1, "irq on touch");
    apb(1'b0, tbsd_pkg::OFS_INTST, 32'h0);
    chk32(rd, 32'h8, "touch event");
    chk1(irq, 1'b0, "irq cleared by read");
    delta <= 16'h0080;  // Inside the hysteresis band
    wait_scans(2);
    chk1(button_output[3], 1'b1, "band keeps state");
    delta <= 16'h0040;
    wait_scans(1);
    chk1(button_output[3], 1'b0, "direct release");
    mask <= 12'h010;
    wait_scans(4);
    chk1(button_output[4], 1'b0, "small signal");
    $display("Test touch done");
  endtask : t_touch
  task automatic t_low_reset;
    mask  <= 12'h040;
    delta <= 16'hffc0;  // Raw well under baseline
    wait_scans(34);
    delta <= 16'h0058;  // Touch only against the reloaded baseline
    wait_scans(3);
    chk1(button_output[6], 1'b1, "baseline reloaded");
    apb(1'b0, tbsd_pkg::OFS_INTST, 32'h0);
    chk32(rd, 32'h40, "reload touch event");
    mask  <= 12'h0;
    delta <= 16'h0200;
    wait_scans(2);
    $display("Test low baseline done");
  endtask : t_low_reset
  task automatic t_guard;
    apb(1'b1, tbsd_pkg::OFS_CTRL, 32'h2);
    mask <= 12'h420;
    wait_scans(4);
    chk1(button_output[5], 1'b0, "suppressed button");
    chk1(irq, 1'b0, "guard event masked");
    apb(1'b0, tbsd_pkg::OFS_STATE, 32'h0);
    chk32(rd & 32'h400, 32'h400, "guard touched");
    mask <= 12'h0;
    wait_scans(2);
    apb(1'b0, tbsd_pkg::OFS_INTST, 32'h0);
    chk32(rd, 32'h400, "guard event");
    apb(1'b1, tbsd_pkg::OFS_CTRL, 32'h1);
    @(posedge pclk);
    chk1(scan_gang, 1'b1, "ganged scan when idle");
    wait_scans(2);
    mask <= 12'h880;
    wait_scans(7);
    chk1(scan_gang, 1'b0, "single scans after touch");
    chk1(button_output[7], 1'b1, "button found");
    $display("Test guard and gang done");
  endtask : t_guard
  task automatic t_on_time;
    reset_dut(1'b1, 2'h2, 1'b0, 1'b1, 2'h3);
    chk1(noise_high, 1'b1, "high immunity");
    apb(1'b0, tbsd_pkg::OFS_STRAP, 32'h0);
    chk32(rd, 32'h3b, "strap readback");
    wait_scans(2);
    mask <= 12'h001;
    wait_scans(98);
    chk1(button_output[0], 1'b0, "input zero 98 samples");
    wait_scans(1);
    chk1(button_output[0], 1'b1, "input zero 99 samples");
    mask <= 12'h0;
    wait_scans(1);
    repeat (500) @(posedge pclk);
    chk1(button_output[0], 1'b1, "on-time hold");
    repeat (700) @(posedge pclk);
    chk1(button_output[0], 1'b0, "on-time over");
    $display("Test on-time done");
  endtask : t_on_time
  task automatic t_analog;
    reset_dut(1'b0, 2'h1, 1'b1, 1'b1, 2'h0);
    chk1(backlight_out, 1'b1, "backlight");
    chk1(analog_mode, 1'b1, "analog mode");
    t_period(298);
    mask <= 12'h004;
    wait_scans(3);
    chk1(button_output[2], 1'b1, "network switch on");
    mask <= 12'h0;
    wait_scans(1);
    chk1(button_output[2], 1'b0, "network switch off");
    $display("Test analog done");
  endtask : t_analog
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_dut(1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
    t_reset();
    t_touch();
    t_low_reset();
    t_guard();
    t_on_time();
    t_analog();
    end_of_test();
  end
endmodule : tbsd_top_tb
`default_nettype wire
